// [design/nfh_pkg.sv]
package nfh_pkg;

    // Clock and pin timing, figures in ns except SYNC_LAT, which counts cycles
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_WP_NS = 12;
    localparam int T_WH_NS = 10;
    localparam int T_WHR_NS = 60;
    localparam int T_WB_NS = 100;
    localparam int T_REA_NS = 20;
    localparam int T_REH_NS = 10;
    localparam int SYNC_LAT = 3;

    // Least times round up to whole cycles
    localparam int WE_LOW_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_HIGH_CYC = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WHR_CYC = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Busy flag needs its fall time plus the synchroniser delay before it is trusted
    localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT;
    // Read data passes the synchroniser and its agreement stage, so the strobe stays low longer
    localparam int RE_LOW_CYC = (T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT + 1;
    localparam int RE_HIGH_CYC = (T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command codes
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_COL_OUT = 8'h05;
    localparam logic [7:0] CMD_COL_OUT_GO = 8'hE0;
    localparam logic [7:0] CMD_READ_CACHE = 8'h31;
    localparam logic [7:0] CMD_READ_LAST = 8'h3F;
    localparam logic [7:0] CMD_MULTI_SETUP = 8'h60;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_PROG_COL = 8'h85;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_RESET = 8'hFF;

    // Address layout
    localparam int COL_W = 13;
    localparam int ROW_W = 17;
    localparam int PAGE_BITS = 6;
    localparam int DISTRICT_BIT = 6;
    localparam logic [5:0] LAST_PAGE = 6'h3F;
    localparam int LEN_W = 13;

    // Operations offered on the user command port
    typedef enum logic [3:0] {
        OP_READ, OP_READ_CACHE, OP_READ_LAST, OP_READ_COL, OP_MULTI_READ,
        OP_PROG_START, OP_PROG_COL, OP_PROG_CONFIRM, OP_READ_DATA, OP_STATUS, OP_RESET
    } nfh_op_type;

    // Kinds of step in an operation script
    typedef enum logic [2:0] {
        K_CMD, K_ADR, K_WRD, K_RDD, K_WAIT, K_END
    } nfh_kind_type;

    // One script step: kind plus command code or address byte selector
    typedef struct packed {
        nfh_kind_type kind;
        logic [7:0] val;
    } nfh_item_type;

endpackage

// [design/nfh_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module nfh_sync
    import nfh_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    // Three stages; output follows only when stages two and three agree
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } nfh_sync_type;

    nfh_sync_type s_q; // Registered state
    nfh_sync_type s_d; // Next state

    // Stage one is read only by stage two
    always_comb begin
        s_d = s_q;
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        if (s_q.s2 == s_q.s3) begin
            s_d.out = s_q.s3;
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.out;

endmodule

`default_nettype wire

// [design/nfh_host.sv]
`timescale 1ns/100ps
`default_nettype none

module nfh_host
    import nfh_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire nfh_op_type cmdOp,
    input wire logic [COL_W-1:0] cmdCol,
    input wire logic [ROW_W-1:0] cmdRow,
    input wire logic [ROW_W-1:0] cmdRow2,
    input wire logic [LEN_W-1:0] cmdLen,
    input wire logic progEnable,
    input wire logic wrValid,
    input wire logic [7:0] wrData,
    output logic wrReady,
    output logic rdValid,
    output logic [7:0] rdData,
    output logic opDone,
    output logic opError,
    output logic chipSelN,
    output logic cmdLatch,
    output logic addrLatch,
    output logic writeStrobeN,
    output logic read_strobe_n,
    output logic writeProtectN,
    output logic [7:0] ioOut,
    output logic ioOe,
    input wire logic [7:0] ioIn,
    input wire logic ready_busy_n
);

    typedef enum {S_IDLE, S_NEXT, S_WLOW, S_WHIGH, S_WFETCH, S_RLOW, S_GAP} nfh_state_type;

    // Whole controller state
    typedef struct packed {
        nfh_state_type st;
        nfh_op_type op;
        logic [3:0] ph;
        logic [LEN_W-1:0] cnt;
        logic [3:0] tmr;
        logic inRd;
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
        logic [ROW_W-1:0] row2;
        logic ceN;
        logic cle;
        logic ale;
        logic weN;
        logic reN;
        logic wpN;
        logic [7:0] ioOut;
        logic ioOe;
        logic rdValid;
        logic [7:0] rdData;
        logic wrReady;
        logic cmdReady;
        logic done;
        logic err;
    } nfh_host_type;

    nfh_host_type s_q; // Registered state
    nfh_host_type s_d; // Next state
    nfh_item_type it; // Current script step
    logic rbSync; // Synchronised ready level
    logic [7:0] ioSync; // Synchronised read data
    logic bad; // Command refused

    // Pin inputs come from outside the clock domain
    nfh_sync #(.W(1)) uRb (
        .clk(clk),
        .nrst(nrst),
        .din(ready_busy_n),
        .dout(rbSync)
    );

    nfh_sync #(.W(8)) uIo (
        .clk(clk),
        .nrst(nrst),
        .din(ioIn),
        .dout(ioSync)
    );

    // Build one script step
    function automatic nfh_item_type mk(input nfh_kind_type k, input logic [7:0] v);
        nfh_item_type r;
        r.kind = k;
        r.val = v;
        return r;
    endfunction

    // Address byte; selector bit 3 picks the second row, unused bits go low
    function automatic logic [7:0] addrByte(input logic [3:0] sel, input logic [COL_W-1:0] c,
                                            input logic [ROW_W-1:0] r1, input logic [ROW_W-1:0] r2);
        logic [ROW_W-1:0] r;
        r = sel[3] ? r2 : r1;
        case (sel[2:0])
            3'h0: addrByte = c[7:0];
            3'h1: addrByte = {3'h0, c[12:8]};
            3'h2: addrByte = r[7:0];
            3'h3: addrByte = r[15:8];
            default: addrByte = {7'h00, r[16]};
        endcase
    endfunction

    // Program operations need the write-protect pin released
    function automatic logic isProg(input nfh_op_type o);
        return (o == OP_PROG_START) || (o == OP_PROG_COL) || (o == OP_PROG_CONFIRM);
    endfunction

    // Script of every operation, one step per phase
    function automatic nfh_item_type script(input nfh_op_type o, input logic [3:0] p);
        script = mk(K_END, 8'h00);
        case (o)
            OP_READ: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_READ_SETUP);
                else if (p <= 4'h5) script = mk(K_ADR, {4'h0, p - 4'h1});
                else if (p == 4'h6) script = mk(K_CMD, CMD_READ_GO);
                else if (p == 4'h7) script = mk(K_WAIT, 8'h00);
            end
            OP_READ_CACHE: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_READ_CACHE);
                else if (p == 4'h1) script = mk(K_WAIT, 8'h00);
            end
            OP_READ_LAST: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_READ_LAST);
                else if (p == 4'h1) script = mk(K_WAIT, 8'h00);
            end
            OP_READ_COL: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_COL_OUT);
                else if (p <= 4'h2) script = mk(K_ADR, {4'h0, p - 4'h1});
                else if (p == 4'h3) script = mk(K_CMD, CMD_COL_OUT_GO);
            end
            OP_MULTI_READ: begin
                if (p == 4'h0 || p == 4'h4) script = mk(K_CMD, CMD_MULTI_SETUP);
                else if (p <= 4'h3) script = mk(K_ADR, {4'h0, p + 4'h1});
                else if (p <= 4'h7) script = mk(K_ADR, {4'h0, p + 4'h5});
                else if (p == 4'h8) script = mk(K_CMD, CMD_READ_GO);
                else if (p == 4'h9) script = mk(K_WAIT, 8'h00);
            end
            OP_PROG_START: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_PROG_SETUP);
                else if (p <= 4'h5) script = mk(K_ADR, {4'h0, p - 4'h1});
                else if (p == 4'h6) script = mk(K_WRD, 8'h00);
            end
            OP_PROG_COL: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_PROG_COL);
                else if (p <= 4'h2) script = mk(K_ADR, {4'h0, p - 4'h1});
                else if (p == 4'h3) script = mk(K_WRD, 8'h00);
            end
            OP_PROG_CONFIRM: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_PROG_GO);
                else if (p == 4'h1) script = mk(K_WAIT, 8'h00);
            end
            OP_READ_DATA: begin
                if (p == 4'h0) script = mk(K_RDD, 8'h00);
            end
            OP_STATUS: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_STATUS);
                else if (p == 4'h1) script = mk(K_RDD, 8'h00);
            end
            OP_RESET: begin
                if (p == 4'h0) script = mk(K_CMD, CMD_RESET);
                else if (p == 4'h1) script = mk(K_WAIT, 8'h00);
            end
            default: script = mk(K_END, 8'h00);
        endcase
    endfunction

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.rdValid = 1'b0;
        s_d.done = 1'b0;
        s_d.err = 1'b0;
        it = script(s_q.op, s_q.ph);
        // Protect pin stays released for the whole multi read
        s_d.wpN = progEnable || (s_q.op == OP_MULTI_READ);
        // Only status and reset may go out while busy; a cached read stepping off the block end is refused
        bad = (!rbSync && cmdOp != OP_STATUS && cmdOp != OP_RESET)
            || (isProg(cmdOp) && !progEnable)
            || (cmdOp == OP_READ_CACHE && s_q.row[PAGE_BITS-1:0] == LAST_PAGE)
            || (cmdOp == OP_MULTI_READ
                && cmdRow[DISTRICT_BIT] == cmdRow2[DISTRICT_BIT]);
        case (s_q.st)
            S_IDLE: begin
                // Chip deselected and strobes idle high between operations
                s_d.ceN = 1'b1;
                s_d.cmdReady = 1'b1;
                if (cmdValid && s_q.cmdReady) begin
                    s_d.cmdReady = 1'b0;
                    if (bad) begin
                        s_d.err = 1'b1;
                    end else begin
                        s_d.op = cmdOp;
                        s_d.ph = 4'h0;
                        s_d.inRd = 1'b0;
                        s_d.ceN = 1'b0;
                        s_d.st = S_NEXT;
                        s_d.cnt = (cmdOp == OP_STATUS) ? LEN_W'(1) : cmdLen;
                        s_d.col = cmdCol;
                        if (cmdOp == OP_READ || cmdOp == OP_PROG_START) begin
                            s_d.row = cmdRow;
                        end else if (cmdOp == OP_MULTI_READ) begin
                            // Same page bits in both districts, either order
                            s_d.row = cmdRow;
                            s_d.row2 = {cmdRow2[ROW_W-1:PAGE_BITS], cmdRow[PAGE_BITS-1:0]};
                        end else if (cmdOp == OP_READ_CACHE) begin
                            // Track the prefetched page so a block crossing is caught
                            s_d.row = s_q.row + ROW_W'(1);
                        end
                    end
                end
            end
            S_NEXT: begin
                case (it.kind)
                    K_CMD: begin
                        s_d.cle = 1'b1;
                        s_d.ioOut = it.val;
                        s_d.ioOe = 1'b1;
                        s_d.weN = 1'b0;
                        s_d.tmr = 4'(WE_LOW_CYC - 1);
                        s_d.st = S_WLOW;
                    end
                    K_ADR: begin
                        s_d.ale = 1'b1;
                        s_d.ioOut = addrByte(it.val[3:0], s_q.col, s_q.row, s_q.row2);
                        s_d.ioOe = 1'b1;
                        s_d.weN = 1'b0;
                        s_d.tmr = 4'(WE_LOW_CYC - 1);
                        s_d.st = S_WLOW;
                    end
                    K_WRD: begin
                        if (s_q.cnt == '0) begin
                            s_d.ph = s_q.ph + 4'h1;
                        end else begin
                            s_d.wrReady = 1'b1;
                            s_d.st = S_WFETCH;
                        end
                    end
                    K_RDD: begin
                        if (s_q.cnt == '0) begin
                            s_d.ph = s_q.ph + 4'h1;
                            s_d.inRd = 1'b0;
                        end else if (!s_q.inRd) begin
                            // Turnaround gap before the first read strobe
                            s_d.inRd = 1'b1;
                            s_d.tmr = 4'(WHR_CYC - 1);
                            s_d.st = S_GAP;
                        end else begin
                            s_d.reN = 1'b0;
                            s_d.tmr = 4'(RE_LOW_CYC - 1);
                            s_d.st = S_RLOW;
                        end
                    end
                    K_WAIT: begin
                        // Give the busy flag time to fall before idling
                        s_d.ph = s_q.ph + 4'h1;
                        s_d.tmr = 4'(WB_CYC - 1);
                        s_d.st = S_GAP;
                    end
                    K_END: begin
                        s_d.done = 1'b1;
                        s_d.st = S_IDLE;
                    end
                    default: s_d.st = S_IDLE;
                endcase
            end
            S_WLOW: begin
                if (s_q.tmr == 4'h0) begin
                    // Rising strobe edge latches the byte
                    s_d.weN = 1'b1;
                    s_d.tmr = 4'(WE_HIGH_CYC - 1);
                    s_d.st = S_WHIGH;
                end else begin
                    s_d.tmr = s_q.tmr - 4'h1;
                end
            end
            S_WHIGH: begin
                if (s_q.tmr == 4'h0) begin
                    s_d.cle = 1'b0;
                    s_d.ale = 1'b0;
                    s_d.ioOe = 1'b0;
                    if (it.kind == K_WRD) begin
                        s_d.cnt = s_q.cnt - LEN_W'(1);
                    end else begin
                        s_d.ph = s_q.ph + 4'h1;
                    end
                    s_d.st = S_NEXT;
                end else begin
                    s_d.tmr = s_q.tmr - 4'h1;
                end
            end
            S_WFETCH: begin
                // Waits for the user byte; the pins hold still meanwhile
                if (wrValid && s_q.wrReady) begin
                    s_d.wrReady = 1'b0;
                    s_d.ioOut = wrData;
                    s_d.ioOe = 1'b1;
                    s_d.weN = 1'b0;
                    s_d.tmr = 4'(WE_LOW_CYC - 1);
                    s_d.st = S_WLOW;
                end
            end
            S_RLOW: begin
                if (s_q.tmr == 4'h0) begin
                    s_d.rdData = ioSync;
                    s_d.rdValid = 1'b1;
                    s_d.reN = 1'b1;
                    s_d.cnt = s_q.cnt - LEN_W'(1);
                    s_d.tmr = 4'(RE_HIGH_CYC - 1);
                    s_d.st = S_GAP;
                end else begin
                    s_d.tmr = s_q.tmr - 4'h1;
                end
            end
            S_GAP: begin
                // Strobes stay high here, also while the device is busy
                if (s_q.tmr == 4'h0) begin
                    s_d.st = S_NEXT;
                end else begin
                    s_d.tmr = s_q.tmr - 4'h1;
                end
            end
            default: s_d.st = S_IDLE;
        endcase
    end

    // State register; pins park inactive and protected at reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.st <= S_IDLE;
            s_q.op <= OP_READ_DATA;
            s_q.ceN <= 1'b1;
            s_q.weN <= 1'b1;
            s_q.reN <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmdReady = s_q.cmdReady;
    assign wrReady = s_q.wrReady;
    assign rdValid = s_q.rdValid;
    assign rdData = s_q.rdData;
    assign opDone = s_q.done;
    assign opError = s_q.err;
    assign chipSelN = s_q.ceN;
    assign cmdLatch = s_q.cle;
    assign addrLatch = s_q.ale;
    assign writeStrobeN = s_q.weN;
    assign read_strobe_n = s_q.reN;
    assign writeProtectN = s_q.wpN;
    assign ioOut = s_q.ioOut;
    assign ioOe = s_q.ioOe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence weHeldHigh;
        s_q.weN [*2];
    endsequence

    sequence reLowRun;
        (!s_q.reN) [*5];
    endsequence

    a_idle_strobes: assert property (
        (s_q.st == S_IDLE && !rbSync) |-> (s_q.weN && s_q.reN))
        else $error("strobe active while idle and busy");

    a_prog_protect: assert property (
        (cmdValid && s_q.cmdReady && isProg(cmdOp) && !progEnable) |=> (s_q.err && s_q.st == S_IDLE))
        else $error("program issued while protected");

    a_read_order: assert property (
        (!s_q.weN && s_q.cle && s_q.ioOut == CMD_READ_GO)
            |-> ((s_q.op == OP_READ && s_q.ph == 4'h6) || (s_q.op == OP_MULTI_READ && s_q.ph == 4'h8)))
        else $error("read confirm out of order");

    a_cache_block: assert property (
        (cmdValid && s_q.cmdReady && cmdOp == OP_READ_CACHE && s_q.row[5:0] == LAST_PAGE) |=> s_q.err)
        else $error("cached read crossed block");

    a_multi_page: assert property (
        (s_q.st == S_NEXT && s_q.op == OP_MULTI_READ && s_q.ph == 4'h5)
            |-> (s_q.row2[5:0] == s_q.row[5:0] && s_q.row2[6] != s_q.row[6]))
        else $error("multi read districts invalid");

    a_multi_wp: assert property (
        (s_q.op == OP_MULTI_READ && $past(s_q.op) == OP_MULTI_READ) |-> s_q.wpN)
        else $error("protect low in multi read");

    a_latch_excl: assert property (
        $fell(s_q.weN) |-> (!(s_q.cle && s_q.ale) && s_q.ioOe && s_q.reN) ##1 weHeldHigh)
        else $error("bad write strobe cycle");

    a_read_byte: assert property (
        $fell(s_q.reN) |-> reLowRun ##1 (s_q.reN && s_q.rdValid && !s_q.ioOe))
        else $error("read strobe timing wrong");

    a_confirm_wait: assert property (
        ($rose(s_q.weN) && s_q.cle && s_q.ioOut == CMD_PROG_GO) |-> s_q.weN [*8])
        else $error("strobe during busy window");

endmodule

`default_nettype wire

// [tb/nfh_dev_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Behavioural memory device seen by the host
module nfh_dev_model #(
    parameter int BUSY_NS = 400
) (
    input wire logic chipSelN,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobeN,
    input wire logic readStrobeN,
    input wire logic writeProtectN,
    input wire logic [7:0] hostIo,
    input wire logic hostIoOe,
    output logic [7:0] devIo,
    output logic readyBusyN
);
    logic [7:0] cmd = 8'h00; // Read setup counts as latched from power-up
    logic [7:0] last = 8'h00; // Last byte put out
    logic [12:0] col = '0;
    logic [16:0] row = '0;
    logic stat = 1'b0; // Status byte mode
    int acnt = 0; // Address cycle position
    logic [7:0] mem [logic [29:0]]; // Programmed bytes
    logic [7:0] pend [logic [12:0]]; // Loaded, not yet programmed
    event goBusy;
    // Blank places read as a pattern so a wrong column shows
    function automatic logic [7:0] dat(input logic [16:0] r, input logic [12:0] c);
        return mem.exists({r, c}) ? mem[{r, c}] : r[7:0] ^ c[7:0] ^ 8'h5A;
    endfunction
    initial readyBusyN = 1'b1;
    // Fixed busy time; a second start while busy is lost, a limitation
    always @(goBusy) begin
        readyBusyN = 1'b0;
        #(BUSY_NS);
        readyBusyN = 1'b1;
    end
    // Everything is latched on the rising write strobe
    always @(posedge writeStrobeN) begin
        if (chipSelN) begin
        end else if (cmdLatch) begin
            // While busy only status and reset get through
            if (readyBusyN || hostIo inside {8'h70, 8'h71, 8'hFF}) begin
                cmd = hostIo;
                stat = hostIo inside {8'h70, 8'h71};
                acnt = (hostIo == 8'h60) ? 2 : 0;
                if (hostIo inside {8'h31, 8'h3F}) begin
                    row++;
                    col = '0;
                end
                if (hostIo == 8'h10 && writeProtectN) begin
                    foreach (pend[c]) mem[{row, c}] = pend[c];
                end
                if (hostIo == 8'h10) begin
                    pend.delete();
                end
                if (hostIo inside {8'h30, 8'h31, 8'h3F, 8'h10, 8'hFF}) begin
                    -> goBusy;
                end
            end
        end else if (addrLatch) begin
            case (acnt)
                0: col[7:0] = hostIo;
                1: col[12:8] = hostIo[4:0];
                2: row[7:0] = hostIo;
                3: row[15:8] = hostIo;
                default: row[16] = hostIo[0];
            endcase
            acnt++;
        end else if (cmd inside {8'h80, 8'h85}) begin
            pend[col] = hostIo;
            col++;
        end
    end
    // One byte per falling read strobe, column steps except in status mode
    always @(negedge readStrobeN) begin
        if (!chipSelN) begin
            last = stat ? {writeProtectN, readyBusyN, readyBusyN, 5'h00} : dat(row, col);
            col = stat ? col : col + 13'h0001;
        end
    end
    // Released port shows an inverted stale value
    assign devIo = (!chipSelN && !readStrobeN && !hostIoOe) ? last : ~last;
endmodule
`default_nettype wire

// [tb/nand_flash_read_program_interface_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module nand_flash_read_program_interface_tb
    import nfh_pkg::*;
();
    localparam logic [ROW_W-1:0] PR = 17'h00100; // Programmed row
    logic clk = 0, nrst = 0, cmdValid = 0, progEnable = 0, wrValid = 0, err, sawBusy;
    nfh_op_type cmdOp = OP_STATUS;
    logic [COL_W-1:0] cmdCol = '0;
    logic [ROW_W-1:0] cmdRow = '0, cmdRow2 = '0;
    logic [LEN_W-1:0] cmdLen = '0;
    logic [7:0] wrData = 8'h00, rdData, ioOut, devIo, rq [$], wq [$];
    logic cmdReady, wrReady, rdValid, opDone, opError, chipSelN, cmdLatch, addrLatch;
    logic writeStrobeN, read_strobe_n, writeProtectN, ioOe, ready_busy_n;
    int errors = 0, check_count = 0, skip;
    wire [7:0] ioIn = ioOe ? ioOut : devIo; // Port level from both drivers
    nfh_host dut (.clk, .nrst, .cmdValid, .cmdReady, .cmdOp, .cmdCol, .cmdRow, .cmdRow2,
        .cmdLen, .progEnable, .wrValid, .wrData, .wrReady, .rdValid, .rdData, .opDone,
        .opError, .chipSelN, .cmdLatch, .addrLatch, .writeStrobeN, .read_strobe_n,
        .writeProtectN, .ioOut, .ioOe, .ioIn, .ready_busy_n);
    // Busy outlasts a status read issued during it
    nfh_dev_model #(.BUSY_NS(1500)) dev (.chipSelN, .cmdLatch, .addrLatch, .writeStrobeN,
        .readStrobeN(read_strobe_n), .writeProtectN, .hostIo(ioOut), .hostIoOe(ioOe),
        .devIo, .readyBusyN(ready_busy_n));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [7:0] pat(input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c);
        return r[7:0] ^ c[7:0] ^ 8'h5A;
    endfunction
    task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One request; feeds write bytes, gathers read bytes, notes busy
    task automatic op(input nfh_op_type o, input logic [COL_W-1:0] c,
            input logic [ROW_W-1:0] r, input logic [ROW_W-1:0] r2, input logic [LEN_W-1:0] n);
        int k = 0;
        rq = {};
        sawBusy = 0;
        skip = 0;
        @(negedge clk);
        cmdOp = o;
        {cmdCol, cmdRow, cmdRow2, cmdLen, cmdValid} = {c, r, r2, n, 1'b1};
        // Ready is looked at away from the edge; the next edge takes the request
        while (!cmdReady && ++k < 50) @(negedge clk);
        @(negedge clk);
        cmdValid = 0;
        while (!opDone && !opError && ++k < 2000) begin
            if (rdValid) rq.push_back(rdData);
            if (!ready_busy_n) sawBusy = 1;
            // Drop valid after a handshake and let wrReady settle before the next byte
            if (wrValid) begin
                wrValid = 0;
                skip = 2;
            end else if (skip > 0) skip--;
            else if (wrReady) begin
                wrValid = 1;
                wrData = wq.pop_front();
            end
            @(negedge clk);
        end
        err = opError;
        if (k >= 2000) begin
            errors++;
            report_and_stop;
        end
    endtask
    // Ready, then the synchroniser delay
    task automatic wait_rdy;
        int k = 0;
        while (!ready_busy_n && ++k < 200) @(negedge clk);
        if (k >= 200) begin
            errors++;
            report_and_stop;
        end
        repeat (6) @(negedge clk);
    endtask
    // Column change then read; x is the flip applied by programming
    task automatic col_rd(input logic [COL_W-1:0] c, input logic [ROW_W-1:0] r, input int n,
            input logic [7:0] x);
        op(OP_READ_COL, c, '0, '0, '0);
        op(OP_READ_DATA, '0, '0, '0, LEN_W'(n));
        for (int i = 0; i < n; i++) chk("byte", rq[i], pat(r, c + COL_W'(i)) ^ x);
    endtask
    task automatic t_read;
        op(OP_READ, 13'h0005, 17'h00043, '0, '0);
        chk("read busy", sawBusy, 8'h01);
        op(OP_READ_DATA, '0, '0, '0, 13'h0001);
        chk("busy refusal", err, 8'h01);
        op(OP_STATUS, '0, '0, '0, '0);
        chk("status busy", rq[0][6], 8'h00);
        wait_rdy;
        op(OP_STATUS, '0, '0, '0, '0);
        chk("status ready", rq[0][7:6], 8'h01);
        col_rd(13'h0005, 17'h00043, 3, 8'h00);
        col_rd(13'h10FE, 17'h00043, 2, 8'h00);
    endtask
    task automatic t_cache;
        op(OP_READ_CACHE, '0, '0, '0, '0);
        chk("cache busy", sawBusy, 8'h01);
        wait_rdy;
        col_rd(13'h0000, 17'h00044, 2, 8'h00);
        op(OP_READ_LAST, '0, '0, '0, '0);
        wait_rdy;
        col_rd(13'h0000, 17'h00045, 2, 8'h00);
        op(OP_READ, '0, 17'h0007F, '0, '0);
        wait_rdy;
        op(OP_READ_CACHE, '0, '0, '0, '0);
        chk("block crossing", err, 8'h01);
    endtask
    task automatic t_multi;
        op(OP_MULTI_READ, '0, 17'h00045, 17'h00080, '0);
        chk("multi busy", sawBusy & !err, 8'h01);
        chk("multi protect", writeProtectN, 8'h01);
        wait_rdy;
        op(OP_MULTI_READ, '0, 17'h00045, 17'h000C5, '0);
        chk("same district", err, 8'h01);
    endtask
    task automatic t_prog;
        op(OP_PROG_START, 13'h000A, PR, '0, 13'h0002);
        chk("protected", err, 8'h01);
        progEnable = 1'b1;
        wq = {pat(PR, 13'h000A) ^ 8'hFF, pat(PR, 13'h000B) ^ 8'hFF, pat(PR, 13'h0014) ^ 8'hFF};
        op(OP_PROG_START, 13'h000A, PR, '0, 13'h0002);
        op(OP_PROG_COL, 13'h0014, '0, '0, 13'h0001);
        op(OP_PROG_CONFIRM, '0, '0, '0, '0);
        chk("program busy", sawBusy, 8'h01);
        op(OP_RESET, '0, '0, '0, '0);
        chk("reset while busy", err, 8'h00);
        wait_rdy;
        op(OP_READ, '0, PR, '0, '0);
        wait_rdy;
        col_rd(13'h000A, PR, 2, 8'hFF);
        col_rd(13'h000C, PR, 1, 8'h00);
        col_rd(13'h0014, PR, 1, 8'hFF);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1;
        wait_rdy;
        t_read;
        t_cache;
        t_multi;
        t_prog;
        report_and_stop;
    end
endmodule
`default_nettype wire
